/* File: hw/lpv_pkg.sv */
// Constants and state type of the lane pattern verifier block
// Notes on behaviour
// - Per lane, timing bit pulses high 8 UI once per pattern cycle; the clock pattern holds it high.
// - While a lane's load bit is high, live settings pass into that lane.
// - When load drops, the lane keeps the last settings until next load.
// - Per-lane mismatch bit sets when locked data differs from expected, or on search timeout.
// - Per-lane bit stays high while verifier searches or trains on pattern.
// - Custom length bit: 0 means 16-bit pattern, 1 means 20-bit; resets 0.
// - Length: PRBS7, 11, 23, 31, then 15 twice, then 20 twice.
// - Select: 0 off, 1 PRBS, 2 clock, 3 custom, 1xx timing-only by length.
// - Custom pattern over three registers; top nibble used only at 20 bits.
// - Three-bit retain threshold governs how long lock is kept.
// - Read-only bit goes high once lane deskew has completed.
// - Rising edge of a self-clearing control bit clears error counters.
// - Writing the self-clearing flag clear bit clears latched test flags whose live flag is low.
// - Three-bit field selects the source of the test flag.
// - Four per-lane bits enable datapath checking per the check selection.
// - Check selection: disparity, FIFO error, overflow, underflow, deskew.
// - Per-lane live test flag follows the selected source, unlatched.
// - Per-lane latched test flag stays set until software clears it.
// - Lane 0 error counter low byte is readable, hardware-updated.
// - Lane 0 counter is 12 bits; upper nibble in next register low bits.
package lpv_pkg;
    localparam int         LPV_LANES        = 4;
    localparam logic [7:0] LPV_OFS_LOAD     = 8'h0E;
    localparam logic [7:0] LPV_OFS_STATUS   = 8'h0F;
    localparam logic [7:0] LPV_OFS_CFG      = 8'h10;
    localparam logic [7:0] LPV_OFS_CP_LO    = 8'h11;
    localparam logic [7:0] LPV_OFS_CP_MID   = 8'h12;
    localparam logic [7:0] LPV_OFS_CP_HI    = 8'h13;
    localparam logic [7:0] LPV_OFS_THR      = 8'h14;
    localparam logic [7:0] LPV_OFS_TSTCTL   = 8'h15;
    localparam logic [7:0] LPV_OFS_DPCTL    = 8'h16;
    localparam logic [7:0] LPV_OFS_FLAGS    = 8'h17;
    localparam logic [7:0] LPV_OFS_CNT_LO   = 8'h18;
    localparam logic [7:0] LPV_OFS_CNT_HI   = 8'h19;
    // Field positions
    localparam int LPV_C20_BIT      = 7;
    localparam int LPV_LEN_LSB      = 3;
    localparam int LPV_ALIGN_BIT    = 7;
    localparam int LPV_CLR_CNT_BIT  = 4;
    localparam int LPV_CLR_FLAG_BIT = 3;
    localparam int LPV_EN_LSB       = 4;
    localparam logic [7:0] LPV_RST_VAL = 8'h00;
    // Pattern select codes
    localparam logic [2:0] LPV_SEL_OFF    = 3'h0;
    localparam logic [2:0] LPV_SEL_PRBS   = 3'h1;
    localparam logic [2:0] LPV_SEL_CLOCK  = 3'h2;
    localparam logic [2:0] LPV_SEL_CUSTOM = 3'h3;
    // Datapath check codes
    localparam logic [2:0] LPV_DP_TMDS    = 3'h0;
    localparam logic [2:0] LPV_DP_FIFO    = 3'h1;
    localparam logic [2:0] LPV_DP_OVF     = 3'h2;
    localparam logic [2:0] LPV_DP_UDF     = 3'h3;
    localparam logic [2:0] LPV_DP_DESKEW  = 3'h4;
    // Timing
    localparam logic [30:0] LPV_PULSE_UI  = 31'h8;
    localparam logic [4:0]  LPV_LOCK_RUN  = 5'h1F;
    localparam int          LPV_CNT_W     = 12;

    typedef struct packed {
        logic [3:0][2:0]  sel;
        logic [3:0][2:0]  len;
        logic [3:0]       c20;
        logic [3:0][19:0] cp;
        logic [3:0][3:0]  tmo;
        logic [3:0]       load;
        logic             g_c20;
        logic [2:0]       g_len;
        logic [2:0]       g_sel;
        logic [19:0]      g_cp;
        logic [2:0]       thr;
        logic [2:0]       tsel;
        logic             clr_cnt;
        logic             clr_flag;
        logic [3:0]       en;
        logic [2:0]       dsel;
        logic [3:0][30:0] hist;
        logic [3:0][30:0] pcnt;
        logic [3:0][4:0]  idx;
        logic [3:0][4:0]  run;
        logic [3:0][2:0]  bad;
        logic [3:0][7:0]  stime;
        logic [3:0]       lock;
        logic [3:0]       fail;
        logic [3:0]       pulse;
        logic [3:0]       live;
        logic [3:0]       sticky;
        logic [3:0][11:0] cnt;
        logic [7:0]       rdata;
    } lpv_state_t;
endpackage

/* File: hw/lpv_top.sv */
// Per-lane pattern verifier, error counter and test flags
`timescale 1ns/10ps
`default_nettype none
module lpv_top
    import lpv_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_n_in,
    // Register port
    input  wire logic                 reg_wr_in,
    input  wire logic [7:0]           reg_addr_in,
    input  wire logic [7:0]           reg_wdata_in,
    output logic      [7:0]           reg_rdata_out,
    // Lane data and datapath events
    input  wire logic [LPV_LANES-1:0] rx_bit_in,
    input  wire logic [3:0]           verifier_timeout_ctl_in,
    input  wire logic [LPV_LANES-1:0] tmds_err_in,
    input  wire logic [LPV_LANES-1:0] fifo_err_in,
    input  wire logic [LPV_LANES-1:0] fifo_ovf_in,
    input  wire logic [LPV_LANES-1:0] fifo_udf_in,
    input  wire logic                 lane_align_done_in,
    // Lane status
    output logic [LPV_LANES-1:0]      pattern_timing_pulse_out,
    output logic [LPV_LANES-1:0]      sticky_test_flag_out
);
    lpv_state_t q;
    lpv_state_t d;

    // Expected next PRBS bit from received history
    function automatic logic prbs_fb(input logic [2:0] len,
                                     input logic [30:0] h);
        unique case (len)
            3'h0:        prbs_fb = h[6] ^ h[5];
            3'h1:        prbs_fb = h[10] ^ h[8];
            3'h2:        prbs_fb = h[22] ^ h[17];
            3'h3:        prbs_fb = h[30] ^ h[27];
            3'h4, 3'h5:  prbs_fb = h[14] ^ h[13];
            3'h6, 3'h7:  prbs_fb = h[19] ^ h[2];
        endcase
    endfunction

    // Cycle length of a PRBS of the given length code
    function automatic logic [30:0] prbs_period(input logic [2:0] len);
        unique case (len)
            3'h0:        prbs_period = 31'h7F;
            3'h1:        prbs_period = 31'h7FF;
            3'h2:        prbs_period = 31'h7FFFFF;
            3'h3:        prbs_period = 31'h7FFFFFFF;
            3'h4, 3'h5:  prbs_period = 31'h7FFF;
            3'h6, 3'h7:  prbs_period = 31'hFFFFF;
        endcase
    endfunction

    // Datapath event selected for one lane
    function automatic logic dp_src(input logic [2:0] sel,
                                    input int l);
        unique case (sel)
            LPV_DP_TMDS:   dp_src = tmds_err_in[l];
            LPV_DP_FIFO:   dp_src = fifo_err_in[l];
            LPV_DP_OVF:    dp_src = fifo_ovf_in[l];
            LPV_DP_UDF:    dp_src = fifo_udf_in[l];
            LPV_DP_DESKEW: dp_src = !lane_align_done_in;
            default:       dp_src = 1'b0;
        endcase
    endfunction

    logic [2:0]  l_sel;
    logic [2:0]  l_len;
    logic        l_c20;
    logic [19:0] l_cp;
    logic [3:0]  l_tmo;
    logic        l_chk;
    logic        l_exp;
    logic        l_err;
    logic        l_evt;
    logic        l_dp;
    logic        l_srch;
    logic [30:0] l_per;
    logic [4:0]  l_clen;
    logic [4:0]  l_idx;
    logic [7:0]  rd;

    always_comb begin
        d = q;
        l_sel = 3'h0;
        l_len = 3'h0;
        l_c20 = 1'b0;
        l_cp = 20'h00000;
        l_tmo = 4'h0;
        l_chk = 1'b0;
        l_exp = 1'b0;
        l_err = 1'b0;
        l_evt = 1'b0;
        l_dp = 1'b0;
        l_srch = 1'b0;
        l_per = 31'h0;
        l_clen = 5'h0;
        l_idx = 5'h0;
        rd = LPV_RST_VAL;
        d.clr_cnt = 1'b0;
        d.clr_flag = 1'b0;

        if (reg_wr_in) begin
            unique case (reg_addr_in)
                LPV_OFS_LOAD:   d.load = reg_wdata_in[3:0];
                LPV_OFS_CFG: begin
                    d.g_c20 = reg_wdata_in[LPV_C20_BIT];
                    d.g_len = reg_wdata_in[LPV_LEN_LSB +: 3];
                    d.g_sel = reg_wdata_in[2:0];
                end
                LPV_OFS_CP_LO:  d.g_cp[7:0] = reg_wdata_in;
                LPV_OFS_CP_MID: d.g_cp[15:8] = reg_wdata_in;
                LPV_OFS_CP_HI:  d.g_cp[19:16] = reg_wdata_in[3:0];
                LPV_OFS_THR:    d.thr = reg_wdata_in[2:0];
                LPV_OFS_TSTCTL: begin
                    // Held one cycle only, so a new write is a new edge
                    d.clr_cnt = reg_wdata_in[LPV_CLR_CNT_BIT];
                    d.clr_flag = reg_wdata_in[LPV_CLR_FLAG_BIT];
                    d.tsel = reg_wdata_in[2:0];
                end
                LPV_OFS_DPCTL: begin
                    d.en = reg_wdata_in[LPV_EN_LSB +: 4];
                    d.dsel = reg_wdata_in[2:0];
                end
                default: ;
            endcase
        end

        for (int l = 0; l < LPV_LANES; l++) begin
            // Live settings while loading, held copy afterwards
            if (q.load[l]) begin
                l_sel = q.g_sel;
                l_len = q.g_len;
                l_c20 = q.g_c20;
                l_cp = q.g_cp;
                l_tmo = verifier_timeout_ctl_in;
                d.sel[l] = q.g_sel;
                d.len[l] = q.g_len;
                d.c20[l] = q.g_c20;
                d.cp[l] = q.g_cp;
                d.tmo[l] = verifier_timeout_ctl_in;
            end else begin
                l_sel = q.sel[l];
                l_len = q.len[l];
                l_c20 = q.c20[l];
                l_cp = q.cp[l];
                l_tmo = q.tmo[l];
            end
            l_clen = l_c20 ? 5'd20 : 5'd16;
            l_chk = (l_sel != LPV_SEL_OFF) && !l_sel[2];

            unique case (l_sel)
                LPV_SEL_OFF:    l_per = 31'h1;
                LPV_SEL_CLOCK:  l_per = 31'h2;
                LPV_SEL_CUSTOM: l_per = {26'h0, l_clen};
                default:        l_per = prbs_period(l_len);
            endcase
            unique case (l_sel)
                LPV_SEL_CLOCK:  l_exp = !q.hist[l][0];
                LPV_SEL_CUSTOM: l_exp = l_cp[q.idx[l]];
                default:        l_exp = prbs_fb(l_len, q.hist[l]);
            endcase
            l_err = l_chk && (rx_bit_in[l] != l_exp);

            // Pattern cycle timer, also runs in timing-only mode
            if (l_sel == LPV_SEL_OFF || q.pcnt[l] >= l_per - 31'h1) begin
                d.pcnt[l] = 31'h0;
            end else begin
                d.pcnt[l] = q.pcnt[l] + 31'h1;
            end
            d.pulse[l] = (l_sel != LPV_SEL_OFF) &&
                         (q.pcnt[l] < LPV_PULSE_UI);

            d.hist[l] = {q.hist[l][29:0], rx_bit_in[l]};
            // Custom slips one bit per miss while searching
            l_idx = q.idx[l] + 5'h1 + {4'h0, l_err && !q.lock[l]};
            if (l_idx >= l_clen) begin
                l_idx = l_idx - l_clen;
            end
            d.idx[l] = (l_sel == LPV_SEL_CUSTOM) ? l_idx : 5'h0;

            if (q.load[l] || !l_chk) begin
                d.lock[l] = 1'b0;
                d.run[l] = 5'h0;
                d.bad[l] = 3'h0;
                d.stime[l] = 8'h00;
                if (q.load[l]) begin
                    d.fail[l] = 1'b0;
                end
            end else if (!q.lock[l]) begin
                d.run[l] = l_err ? 5'h0 : q.run[l] + 5'h1;
                d.lock[l] = !l_err && (q.run[l] == LPV_LOCK_RUN - 5'h1);
                // Timeout guards against a lane that never trains
                if (q.stime[l] == {l_tmo, 4'hF} && l_tmo != 4'h0) begin
                    d.fail[l] = 1'b1;
                end else begin
                    d.stime[l] = q.stime[l] + 8'h01;
                end
            end else if (l_err) begin
                d.fail[l] = 1'b1;
                // Lock dropped only after a burst beyond threshold
                if (q.bad[l] >= q.thr) begin
                    d.lock[l] = 1'b0;
                    d.run[l] = 5'h0;
                    d.bad[l] = 3'h0;
                    d.stime[l] = 8'h00;
                end else begin
                    d.bad[l] = q.bad[l] + 3'h1;
                end
            end else begin
                d.bad[l] = 3'h0;
            end
            l_srch = l_chk && !q.lock[l];

            l_dp = q.en[l] && dp_src(q.dsel, l);
            l_evt = (|q.en) ? l_dp : (l_err && q.lock[l]);
            if (q.clr_cnt) begin
                d.cnt[l] = 12'h000;
            end else if (l_evt && q.cnt[l] != 12'hFFF) begin
                d.cnt[l] = q.cnt[l] + 12'h001;
            end

            unique case (q.tsel)
                3'h0:    d.live[l] = l_dp;
                3'h1:    d.live[l] = q.fail[l];
                3'h2:    d.live[l] = l_srch;
                3'h3:    d.live[l] = q.pulse[l];
                default: d.live[l] = 1'b0;
            endcase
            // Set wins over a clear in the same cycle
            if (q.live[l]) begin
                d.sticky[l] = 1'b1;
            end else if (q.clr_flag) begin
                d.sticky[l] = 1'b0;
            end
        end

        unique case (reg_addr_in)
            LPV_OFS_LOAD:   rd = {q.pulse, q.load};
            LPV_OFS_STATUS: rd = {q.fail, ~q.lock & srch_mask(q)};
            LPV_OFS_CFG:    rd = {q.g_c20, 1'b0, q.g_len, q.g_sel};
            LPV_OFS_CP_LO:  rd = q.g_cp[7:0];
            LPV_OFS_CP_MID: rd = q.g_cp[15:8];
            LPV_OFS_CP_HI:  rd = {4'h0, q.g_cp[19:16]};
            LPV_OFS_THR:    rd = {5'h00, q.thr};
            LPV_OFS_TSTCTL: rd = {lane_align_done_in, 4'h0, q.tsel};
            LPV_OFS_DPCTL:  rd = {q.en, 1'b0, q.dsel};
            LPV_OFS_FLAGS:  rd = {q.sticky, q.live};
            LPV_OFS_CNT_LO: rd = q.cnt[0][7:0];
            LPV_OFS_CNT_HI: rd = {4'h0, q.cnt[0][11:8]};
            default:        rd = LPV_RST_VAL;
        endcase
        d.rdata = rd;
    end

    // Lanes whose held or live mode is a checking mode
    function automatic logic [3:0] srch_mask(input lpv_state_t s);
        logic [2:0] m;
        srch_mask = 4'h0;
        for (int l = 0; l < LPV_LANES; l++) begin
            m = s.load[l] ? s.g_sel : s.sel[l];
            srch_mask[l] = (m != LPV_SEL_OFF) && !m[2];
        end
    endfunction

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_out = q.rdata;
    assign pattern_timing_pulse_out = q.pulse;
    assign sticky_test_flag_out = q.sticky;
endmodule
`default_nettype wire

/* File: test/lpv_top_checker.sv */
// Port-level assertions for the lane pattern verifier
`timescale 1ns/10ps
`default_nettype none
module lpv_top_checker
    import lpv_pkg::*;
(
    // Watched ports
    input wire logic                 core_clk_in,
    input wire logic                 rst_n_in,
    input wire logic                 reg_wr_in,
    input wire logic [7:0]           reg_addr_in,
    input wire logic [7:0]           reg_wdata_in,
    input wire logic [7:0]           reg_rdata_out,
    input wire logic [LPV_LANES-1:0] pattern_timing_pulse_out,
    input wire logic [LPV_LANES-1:0] sticky_test_flag_out
);
    default clocking dc @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_cfg_bit_six: assert property (
        $past(reg_addr_in) == LPV_OFS_CFG |-> reg_rdata_out[6] == 1'b0)
        else $error("config reserved bit set");
    a_cp_top_zero: assert property (
        $past(reg_addr_in) == LPV_OFS_CP_HI |-> reg_rdata_out[7:4] == 4'h0)
        else $error("custom high upper nibble set");
    a_thr_upper_zero: assert property (
        $past(reg_addr_in) == LPV_OFS_THR |-> reg_rdata_out[7:3] == 5'h00)
        else $error("threshold upper bits set");
    a_clear_bits_zero: assert property (
        $past(reg_addr_in) == LPV_OFS_TSTCTL |-> reg_rdata_out[6:3] == 4'h0)
        else $error("self clearing bits read back");
    a_cnt_hi_nibble: assert property (
        $past(reg_addr_in) == LPV_OFS_CNT_HI |-> reg_rdata_out[7:4] == 4'h0)
        else $error("counter high upper nibble set");
    a_cp_readback: assert property (
        reg_wr_in && reg_addr_in == LPV_OFS_CP_LO ##1
        !reg_wr_in && reg_addr_in == LPV_OFS_CP_LO
        |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("custom low readback wrong");
    a_flags_reg_out: assert property (
        $past(reg_addr_in) == LPV_OFS_FLAGS
        |-> reg_rdata_out[7:4] == $past(sticky_test_flag_out))
        else $error("sticky field differs from port");
    a_pulse_reg_out: assert property (
        $past(reg_addr_in) == LPV_OFS_LOAD
        |-> reg_rdata_out[7:4] == $past(pattern_timing_pulse_out))
        else $error("pulse field differs from port");
    // Clear takes one extra edge, so two cycles are excluded
    a_sticky_holds: assert property (
        sticky_test_flag_out[0]
        && !(reg_wr_in && reg_addr_in == LPV_OFS_TSTCTL && reg_wdata_in[3])
        && !$past(reg_wr_in && reg_addr_in == LPV_OFS_TSTCTL
        && reg_wdata_in[3]) |=> sticky_test_flag_out[0])
        else $error("sticky flag dropped without clear");
    a_pulse_eight: assert property (
        $rose(pattern_timing_pulse_out[0])
        |-> pattern_timing_pulse_out[0][*8])
        else $error("timing pulse shorter than eight");

    c_sticky_set: cover property ($rose(sticky_test_flag_out[0]));
    c_pulse_seen: cover property ($rose(pattern_timing_pulse_out[0]));
    c_flag_clear: cover property ($fell(sticky_test_flag_out[0]));
endmodule
bind lpv_top lpv_top_checker u_lpv_top_checker (
    .core_clk_in, .rst_n_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .pattern_timing_pulse_out, .sticky_test_flag_out);
`default_nettype wire

/* File: test/lpv_top_bench.sv */
// Register-level bench of the lane pattern verifier
`timescale 1ns/10ps
`default_nettype none
module lpv_top_bench import lpv_pkg::*;;
    logic        core_clk_in;
    logic        rst_n_in;
    logic        reg_wr_in;
    logic [7:0]  reg_addr_in;
    logic [7:0]  reg_wdata_in;
    logic [7:0]  reg_rdata_out;
    logic [3:0]  rx_bit_in = 4'h0;
    logic [3:0]  verifier_timeout_ctl_in;
    logic [3:0]  ev [4];
    logic        lane_align_done_in;
    logic [3:0]  pattern_timing_pulse_out;
    logic [3:0]  sticky_test_flag_out;
    logic        rx_run;
    int          error_cnt;
    int          checks;
    logic [7:0]  ta [11] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
                            8'h16, 8'h17, 8'h18, 8'h19, 8'h1A};
    logic [7:0]  te [11] = '{8'h00, 8'hBF, 8'hA5, 8'h5A, 8'h0F, 8'h07,
                            8'hF7, 8'h00, 8'h00, 8'h00, 8'h00};

    lpv_top u_lpv_top (
        .core_clk_in              (core_clk_in),
        .rst_n_in                 (rst_n_in),
        .reg_wr_in                (reg_wr_in),
        .reg_addr_in              (reg_addr_in),
        .reg_wdata_in             (reg_wdata_in),
        .reg_rdata_out            (reg_rdata_out),
        .rx_bit_in                (rx_bit_in),
        .verifier_timeout_ctl_in  (verifier_timeout_ctl_in),
        .tmds_err_in              (ev[0]),
        .fifo_err_in              (ev[1]),
        .fifo_ovf_in              (ev[2]),
        .fifo_udf_in              (ev[3]),
        .lane_align_done_in       (lane_align_done_in),
        .pattern_timing_pulse_out (pattern_timing_pulse_out),
        .sticky_test_flag_out     (sticky_test_flag_out)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    // Clock pattern stimulus; rx_run is set by NBA to avoid a race
    always @(negedge core_clk_in) begin
        if (rx_run) begin
            rx_bit_in <= ~rx_bit_in;
        end
    end

    task automatic print_verdict;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge core_clk_in);
        // Idle edge so a following write raises a fresh strobe
        reg_wr_in = 1'b0;
        @(negedge core_clk_in);
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [7:0] m,
                           input logic [7:0] e);
        reg_addr_in = a;
        @(negedge core_clk_in);
        checks++;
        if ((reg_rdata_out & m) !== e) begin
            error_cnt++;
            $display("MISMATCH %0t addr %h got %h exp %h", $time, a,
                     reg_rdata_out, e);
        end
    endtask

    task automatic out_chk(input logic [3:0] got, input logic [3:0] e);
        checks++;
        if (got !== e) begin
            error_cnt++;
            $display("MISMATCH %0t port got %h exp %h", $time, got, e);
        end
    endtask

    task automatic wait_pulse;
        int i;
        for (i = 0; i < 64 && pattern_timing_pulse_out[0] !== 1'b1; i++) begin
            @(negedge core_clk_in);
        end
        if (i == 64) begin
            error_cnt++;
            $display("MISMATCH %0t timing pulse never rose", $time);
            print_verdict();
        end
    endtask

    initial begin
        int c;
        int k;
        logic [7:0] a;
        rst_n_in = 1'b0;
        reg_wr_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        verifier_timeout_ctl_in = 4'h0;
        rx_run = 1'b0;
        lane_align_done_in = 1'b0;
        for (k = 0; k < 4; k++) ev[k] = 4'h0;
        error_cnt = 0;
        checks = 0;
        repeat (5) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        for (a = 8'h0D; a <= 8'h1A; a++) reg_chk(a, 8'hFF, 8'h00);
        // Read-only and reserved bits must not take the written ones
        for (k = 0; k < 11; k++) begin
            reg_wr(ta[k], (ta[k] == 8'h11) ? 8'hA5 : ((ta[k] == 8'h12) ?
                   8'h5A : 8'hFF));
            reg_chk(ta[k], 8'hFF, te[k]);
        end
        reg_wr(LPV_OFS_CFG, 8'h00);
        reg_wr(LPV_OFS_TSTCTL, 8'h00);
        lane_align_done_in = 1'b1;
        // Lane 0 sees the selected type, then one cycle of only the other types
        for (c = 0; c < 4; c++) begin
            reg_wr(LPV_OFS_DPCTL, {5'h02, c[2:0]});
            for (k = 0; k < 4; k++) ev[k] = (k == c) ? 4'hF : 4'hE;
            repeat ((c == 0) ? 258 : c + 2) @(negedge core_clk_in);
            for (k = 0; k < 4; k++) ev[k] = (k == c) ? 4'hE : 4'hF;
            @(negedge core_clk_in);
            for (k = 0; k < 4; k++) ev[k] = 4'h0;
        end
        reg_wr(LPV_OFS_DPCTL, 8'h14);
        repeat (3) @(negedge core_clk_in);
        lane_align_done_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        lane_align_done_in = 1'b1;
        repeat (2) @(negedge core_clk_in);
        reg_chk(LPV_OFS_CNT_LO, 8'hFF, 8'h11);
        reg_chk(LPV_OFS_CNT_HI, 8'hFF, 8'h01);
        reg_chk(LPV_OFS_TSTCTL, 8'hFF, 8'h80);
        out_chk(sticky_test_flag_out, 4'h1);
        reg_chk(LPV_OFS_FLAGS, 8'hFF, 8'h10);
        reg_wr(LPV_OFS_TSTCTL, 8'h08);
        repeat (2) @(negedge core_clk_in);
        reg_chk(LPV_OFS_FLAGS, 8'hFF, 8'h00);
        out_chk(sticky_test_flag_out, 4'h0);
        reg_wr(LPV_OFS_DPCTL, 8'h00);
        reg_wr(LPV_OFS_TSTCTL, 8'h12);
        repeat (2) @(negedge core_clk_in);
        reg_chk(LPV_OFS_CNT_LO, 8'hFF, 8'h00);
        reg_wr(LPV_OFS_CFG, 8'h02);
        reg_wr(LPV_OFS_LOAD, 8'h01);
        rx_run <= 1'b1;
        repeat (2) @(negedge core_clk_in);
        reg_chk(LPV_OFS_STATUS, 8'hFF, 8'h01);
        reg_chk(LPV_OFS_FLAGS, 8'h0F, 8'h01);
        reg_wr(LPV_OFS_LOAD, 8'h00);
        reg_wr(LPV_OFS_CFG, 8'h00);
        repeat (40) @(negedge core_clk_in);
        reg_chk(LPV_OFS_STATUS, 8'hFF, 8'h00);
        wait_pulse();
        out_chk(pattern_timing_pulse_out, 4'h1);
        reg_chk(LPV_OFS_LOAD, 8'h1F, 8'h10);
        rx_run <= 1'b0;
        @(negedge core_clk_in);
        rx_run <= 1'b1;
        repeat (4) @(negedge core_clk_in);
        reg_chk(LPV_OFS_STATUS, 8'hF0, 8'h10);
        reg_chk(LPV_OFS_CNT_LO, 8'hFF, 8'h01);
        // Lane 1 custom pattern never matches the toggling stream
        verifier_timeout_ctl_in = 4'h1;
        reg_wr(LPV_OFS_CFG, 8'h03);
        reg_wr(LPV_OFS_LOAD, 8'h02);
        reg_chk(LPV_OFS_STATUS, 8'h22, 8'h02);
        reg_wr(LPV_OFS_LOAD, 8'h00);
        // Timeout must come from the held copy, not the live input
        verifier_timeout_ctl_in = 4'h0;
        repeat (40) @(negedge core_clk_in);
        reg_chk(LPV_OFS_STATUS, 8'h22, 8'h22);
        print_verdict();
    end
endmodule
`default_nettype wire
